/* dv/fmt_sink.sv */
// formatter sink model: accepts stream words promptly or with random stalls
// assumes it shares the generator's clock and reset
`timescale 1ns/10ps
module fmt_sink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  output logic ready_o
);
  int seed = 50;
  int rv;
  // long stalls keep the two-entry buffer full, so the upstream refusal gets exercised
  always @(posedge clk_i) begin
    rv = $random(seed);
    ready_o <= !rst_i && (!slow_i || rv[1:0] == 2'b00);
  end
endmodule

/* dv/tb_adc_output_test_pattern_generator.sv */
// self-checking bench for the converter test pattern generator
// assumes the package, the design sources and the sink model are compiled first
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_adc_output_test_pattern_generator;
  import tpg_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic ddc_mode_i = 1'b0, adc_valid_i = 1'b0;
  logic [14:0] wb_adr_i = 15'h0000;
  logic [3:0] wb_sel_i = 4'h0, mode_a, mode_b;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, r;
  logic wb_ack_o, in_ready_o, out_valid_o, out_ready_i;
  adc_pair_t adc_i = 28'h0000000, s;
  sample_t out_o;
  logic [13:0] prev_i, prev_q, first_i, first_q, p_i, p_q;
  logic [15:0] upat [4], ei, eq;
  logic [7:0] dv [4] = '{8'h01, 8'h04, 8'h05, 8'h00};
  bit feed, single, en_i, en_q, slow;
  int n_errors, check_count, nacc, n_want, k, rv, seed = 50;
  adc_pair_t qa [$];
  int qk [$];

  test_pattern_gen dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ddc_mode_i(ddc_mode_i),
    .adc_valid_i(adc_valid_i), .adc_i(adc_i), .in_ready_o(in_ready_o),
    .out_valid_o(out_valid_o), .out_o(out_o), .out_ready_i(out_ready_i));
  fmt_sink sink (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .ready_o(out_ready_i));

  initial forever #4 clk_i = ~clk_i;

  // {fmt, tst, word} expected on one lane; first word of a relational pattern is free
  function automatic logic [15:0] lane_exp(input logic [3:0] m, input bit e,
      input logic [13:0] adc, g, p, input int k);
    logic [13:0] w;
    if (!e || m == 4'h0 || (m > 4'h8 && m < 4'hF)) return {2'b10, adc};
    case (m)
      4'h1: w = 14'h0000;
      4'h2: w = 14'h1FFF;
      4'h3: w = 14'h2000;
      4'h4: w = (k == 0 && (g == 14'h1555 || g == 14'h2AAA)) ? g :
                (p == 14'h1555 ? 14'h2AAA : 14'h1555);
      4'h7: w = (k == 0 && (g == 14'h0000 || g == 14'h3FFF)) ? g : ~p;
      4'h8: w = (k >= 4 && single) ? 14'h0000 : upat[k % 4][15:2];
      4'hF: w = (k == 0) ? g : p + 14'h0001;
      default: w = (k > 0 && g == p) ? ~g : g;
    endcase
    return {m < 4'h5, 1'b1, w};
  endfunction

  always @(posedge clk_i) begin
    if (!rst_i) begin
      `CHK("in_ready", qa.size() < 2, in_ready_o)
      `CHK("out_valid", qa.size() > 0, out_valid_o)
      if (out_valid_o && out_ready_i && qa.size() > 0) begin
        s = qa.pop_front();
        k = qk.pop_front();
        ei = lane_exp(mode_a, !ddc_mode_i || en_i, s.a, out_o.i, prev_i, k);
        eq = lane_exp(mode_b, !ddc_mode_i || en_q, s.b, out_o.q, prev_q, k);
        `CHK("lane_i", ei, {out_o.fmt_i, out_o.tst_i, out_o.i})
        `CHK("lane_q", eq, {out_o.fmt_q, out_o.tst_q, out_o.q})
        if (k == 0) begin
          first_i = out_o.i;
          first_q = out_o.q;
        end
        prev_i = out_o.i;
        prev_q = out_o.q;
      end
      if (adc_valid_i && in_ready_o) begin
        qa.push_back(adc_i);
        qk.push_back(nacc);
        nacc++;
      end
    end
    rv = $random(seed);
    adc_valid_i <= feed && nacc < n_want && rv[0];
    adc_i <= 28'($random(seed));
  end

  task automatic wb(input bit we, input logic [12:0] idx, input logic [7:0] d,
      output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    wb_sel_i <= 4'hF;
    // no latency is assumed here; a lost ack is caught by the watchdog
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [12:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [12:0] idx, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, q);
    `CHK("reg_read", {24'h000000, e}, q)
  endtask

  task automatic set_modes(input logic [7:0] a, input logic [7:0] b);
    wr(IDX_TMODE_A, a);
    wr(IDX_TMODE_B, b);
    mode_a = a[3:0];
    mode_b = b[3:0];
    single = a[7];
  endtask

  task automatic run_seg(input int n);
    int t;
    nacc = 0;
    n_want = n;
    feed = 1'b1;
    t = 0;
    while ((nacc < n || qa.size() > 0) && t < 2000) begin
      @(posedge clk_i);
      t++;
    end
    feed = 1'b0;
    if (t >= 2000) begin
      n_errors++;
      $display("BAD stream exp drained got stalled");
      end_sim;
    end
  endtask

  task end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #(30000 * 8);
    n_errors++;
    $display("BAD watchdog exp done got timeout");
    end_sim;
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(IDX_TMODE_A, 8'h00);
    rd(IDX_DDC3_TEST, 8'h00);
    wr(13'h0100, 8'h5A);
    rd(13'h0100, 8'h00);
    for (int j = 0; j < 8; j++) begin
      r = $random(seed);
      wr(13'(IDX_UPAT0 + j), r[7:0]);
      rd(13'(IDX_UPAT0 + j), r[7:0]);
      upat[j / 2][8 * (j % 2) +: 8] = r[7:0];
    end
    // every code on lane i, a different one on lane q
    for (int m = 0; m < 16; m++) begin
      slow = m[0];
      set_modes(8'(m), 8'(15 - m));
      run_seg(12);
    end
    set_modes(8'h88, 8'h88);
    run_seg(10);
    ddc_mode_i <= 1'b1;
    set_modes(8'h02, 8'h04);
    for (int d = 0; d < 4; d++) begin
      wr(13'(IDX_DDC0_TEST + 13'h0020 * d), dv[d]);
      en_i = dv[d][0];
      en_q = dv[d][2];
      run_seg(8);
      wr(13'(IDX_DDC0_TEST + 13'h0020 * d), 8'h00);
    end
    ddc_mode_i <= 1'b0;
    // holding a restart bit and releasing it must replay the same opening words
    for (int b = 4; b < 6; b++) begin
      set_modes(8'h05 | (8'h01 << b), 8'h06);
      set_modes(8'h05, 8'h06);
      run_seg(6);
      if (b == 4) begin
        p_i = first_i;
        p_q = first_q;
      end
    end
    `CHK("pn_long_restart", p_i, first_i)
    `CHK("pn_short_restart", p_q, first_q)
    end_sim;
  end
endmodule

/* src/test_pattern_gen.sv */
// converter output test pattern generator with wishbone control registers
// assumes samples arrive with a valid strobe on the encode clock and the
// formatter drains a valid/ready stream
//
// Overview of operation
// [R01] an active test mode replaces converter samples by the generated pattern
// [R02] constant and checkerboard patterns are marked for formatting, the rest bypass it
// [R03] bit 4 or bit 5 of the test mode control register restarts the pn generators
// [R04] patterns advance only on accepted samples and ignore the converter input
// [R05] software enables patterns per decimating channel via bits 0 and 2 of its register
// [R06] in decimating modes i carries the channel a pattern and q the channel b pattern
// [R07] codes 0 to 3 give off, midscale, positive and negative full scale
// [R08] code 4 alternates 0x1555 and 0x2AAA
// [R09] code 5 gives the long pn sequence x^23 + x^18 + 1 from seed 0x3AFF
// [R10] code 6 gives the short pn sequence x^9 + x^5 + 1 from seed 0x0092
// [R11] code 7 toggles between 0x0000 and 0x3FFF
// [R12] code 8 outputs bits 15:2 of four user words, repeating after the fourth
// [R13] in single user mode the four words are sent once and then 0x0000 is held
// [R14] code 15 gives a ramp that increments each sample modulo 2^14; it holds on a sample accepted while a mode register is written
// [R15] unassigned codes act as off and pass converter data unchanged
`timescale 1ns/10ps
module test_pattern_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tpg_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ddc_mode_i,
  input wire logic adc_valid_i,
  input wire tpg_pkg::adc_pair_t adc_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output tpg_pkg::sample_t out_o,
  input wire logic out_ready_i
);
  import tpg_pkg::*;

  typedef struct packed {
    logic pend;
    logic ack;
    logic usel;
    logic [31:0] dat;
    logic [3:0][7:0] ddc_en;
    logic [7:0] mode_a;
    logic [7:0] mode_b;
    logic [22:0] pn_long;
    logic [8:0] pn_short;
    logic phase;
    logic [13:0] ramp;
    logic [1:0] uidx;
    logic udone;
    sample_t [1:0] buf_q;
    logic [1:0] cnt;
    logic in_rdy;
    logic out_vld;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [IDX_W-1:0] idx;
  logic req;
  logic acc;
  logic pop;
  logic mem_we;
  logic [15:0] uword;
  logic [7:0] ubyte;
  logic [14:0] pat_a;
  logic [14:0] pat_b;
  logic [36:0] pnl;
  logic [22:0] pns;
  logic act_a;
  logic act_b;
  sample_t smp;

  function automatic logic is_user(input logic [IDX_W-1:0] x);
    return (x >= IDX_UPAT0) && (x <= IDX_UPAT7);
  endfunction

  function automatic logic [2:0] user_byte(input logic [IDX_W-1:0] x);
    logic [IDX_W-1:0] d;
    d = x - IDX_UPAT0;
    return d[2:0];
  endfunction

  // unassigned codes count as off so converter data flows untouched
  function automatic logic code_valid(input logic [3:0] c);
    return ((c >= MODE_MID) && (c <= MODE_USER)) || (c == MODE_RAMP); // [R15]
  endfunction

  // fourteen shifts per sample; returns {next state, collected bits}
  function automatic logic [36:0] pn_long_step(input logic [22:0] s);
    logic [22:0] t;
    logic [13:0] o;
    t = s;
    o = '0;
    for (int k = 0; k < SAMPLE_W; k++) begin
      o = {o[12:0], t[22] ^ t[17]};
      t = {t[21:0], t[22] ^ t[17]};
    end
    return {t, o}; // [R09]
  endfunction

  function automatic logic [22:0] pn_short_step(input logic [8:0] s);
    logic [8:0] t;
    logic [13:0] o;
    t = s;
    o = '0;
    for (int k = 0; k < SAMPLE_W; k++) begin
      o = {o[12:0], t[8] ^ t[4]};
      t = {t[7:0], t[8] ^ t[4]};
    end
    return {t, o}; // [R10]
  endfunction

  // returns {formatting allowed, pattern word}
  function automatic logic [14:0] pattern(
    input logic [7:0] m,
    input logic ph,
    input logic [13:0] pl,
    input logic [13:0] ps,
    input logic [13:0] rmp,
    input logic [15:0] uw,
    input logic ud
  );
    logic [14:0] r;
    r = {1'b1, PAT_MID};
    unique case (m[3:0])
      MODE_MID: r = {1'b1, PAT_MID}; // [R07] [R02]
      MODE_POS_FS: r = {1'b1, PAT_POS_FS}; // [R07]
      MODE_NEG_FS: r = {1'b1, PAT_NEG_FS}; // [R07]
      MODE_CHECKER: r = {1'b1, ph ? PAT_CHECK_1 : PAT_CHECK_0}; // [R08]
      MODE_PN_LONG: r = {1'b0, pl}; // [R09] [R02]
      MODE_PN_SHORT: r = {1'b0, ps}; // [R10]
      MODE_TOGGLE: r = {1'b0, ph ? PAT_ONES : PAT_ZEROS}; // [R11]
      MODE_USER: r = {1'b0, (m[TM_USER_SINGLE] && ud) ? PAT_ZEROS : uw[15:2]}; // [R12] [R13]
      MODE_RAMP: r = {1'b0, rmp}; // [R14]
      default: r = {1'b1, PAT_MID};
    endcase
    return r;
  endfunction

  assign idx = wb_adr_i[WB_ADR_W-1:2];
  assign req = wb_cyc_i && wb_stb_i && !st_r.pend && !st_r.ack;
  assign mem_we = req && wb_we_i && wb_sel_i[0] && is_user(idx);
  // a sample is taken only while the buffer has room, so stalls back-press the source
  assign acc = adc_valid_i && st_r.in_rdy;
  assign pop = st_r.out_vld && out_ready_i;

  user_pattern_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(mem_we),
    .wr_addr_i(user_byte(idx)),
    .wr_data_i(wb_dat_i[7:0]),
    .word_addr_i(st_nxt.uidx),
    .word_o(uword),
    .byte_addr_i(user_byte(idx)),
    .byte_o(ubyte)
  );

  always_comb begin
    st_nxt = st_r;
    pnl = pn_long_step(st_r.pn_long);
    pns = pn_short_step(st_r.pn_short);
    pat_a = pattern(st_r.mode_a, st_r.phase, pnl[13:0], pns[13:0], st_r.ramp, uword,
      st_r.udone);
    pat_b = pattern(st_r.mode_b, st_r.phase, pnl[13:0], pns[13:0], st_r.ramp, uword,
      st_r.udone);
    act_a = code_valid(st_r.mode_a[3:0]) && (!ddc_mode_i ||
      (st_r.ddc_en[0][DDC_EN_I_BIT] || st_r.ddc_en[1][DDC_EN_I_BIT] ||
      st_r.ddc_en[2][DDC_EN_I_BIT] || st_r.ddc_en[3][DDC_EN_I_BIT])); // [R05] [R06]
    act_b = code_valid(st_r.mode_b[3:0]) && (!ddc_mode_i ||
      (st_r.ddc_en[0][DDC_EN_Q_BIT] || st_r.ddc_en[1][DDC_EN_Q_BIT] ||
      st_r.ddc_en[2][DDC_EN_Q_BIT] || st_r.ddc_en[3][DDC_EN_Q_BIT])); // [R05] [R06]
    // converter data is detached whenever a pattern is active on that output
    smp.i = act_a ? pat_a[13:0] : adc_i.a; // [R01] [R04]
    smp.q = act_b ? pat_b[13:0] : adc_i.b; // [R01] [R06]
    smp.fmt_i = act_a ? pat_a[14] : 1'b1; // [R02]
    smp.fmt_q = act_b ? pat_b[14] : 1'b1; // [R02]
    smp.tst_i = act_a;
    smp.tst_q = act_b;

    // bus: request seen, then one wait state so the byte store can answer
    st_nxt.pend = req;
    st_nxt.ack = st_r.pend;
    if (req) begin
      st_nxt.usel = is_user(idx);
      st_nxt.dat = '0;
      unique case (idx)
        IDX_DDC0_TEST: st_nxt.dat[7:0] = st_r.ddc_en[0];
        IDX_DDC1_TEST: st_nxt.dat[7:0] = st_r.ddc_en[1];
        IDX_DDC2_TEST: st_nxt.dat[7:0] = st_r.ddc_en[2];
        IDX_DDC3_TEST: st_nxt.dat[7:0] = st_r.ddc_en[3];
        IDX_TMODE_A: st_nxt.dat[7:0] = st_r.mode_a;
        IDX_TMODE_B: st_nxt.dat[7:0] = st_r.mode_b;
        default: st_nxt.dat = '0;
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        unique case (idx)
          IDX_DDC0_TEST: st_nxt.ddc_en[0] = wb_dat_i[7:0]; // [R05]
          IDX_DDC1_TEST: st_nxt.ddc_en[1] = wb_dat_i[7:0];
          IDX_DDC2_TEST: st_nxt.ddc_en[2] = wb_dat_i[7:0];
          IDX_DDC3_TEST: st_nxt.ddc_en[3] = wb_dat_i[7:0];
          IDX_TMODE_A: st_nxt.mode_a = wb_dat_i[7:0];
          IDX_TMODE_B: st_nxt.mode_b = wb_dat_i[7:0];
          default: st_nxt.usel = is_user(idx);
        endcase
        // a mode write restarts the user word sequence from the first word
        if (idx == IDX_TMODE_A || idx == IDX_TMODE_B) begin
          st_nxt.uidx = 2'h0; // [R12]
          st_nxt.udone = 1'b0;
        end
      end
    end
    if (st_r.pend && st_r.usel) begin
      st_nxt.dat = {24'h000000, ubyte};
    end

    // generators step once per accepted sample only, and not in a cycle that writes a mode register
    if (acc && !(req && wb_we_i && wb_sel_i[0] &&
        (idx == IDX_TMODE_A || idx == IDX_TMODE_B))) begin
      st_nxt.phase = !st_r.phase; // [R08] [R11]
      st_nxt.ramp = st_r.ramp + 14'h0001; // [R14]
      st_nxt.pn_long = pnl[36:14];
      st_nxt.pn_short = pns[22:14];
      st_nxt.uidx = st_r.uidx + 2'h1; // [R12]
      if (st_r.uidx == 2'h3) begin
        st_nxt.udone = 1'b1; // [R13]
      end
    end
    // reset bits hold the pn state at its seed for as long as they stay set
    if (st_r.mode_a[TM_PN_LONG_RST] || st_r.mode_a[TM_PN_SHORT_RST] ||
        st_r.mode_b[TM_PN_LONG_RST] || st_r.mode_b[TM_PN_SHORT_RST]) begin
      st_nxt.pn_long = PN_LONG_SEED; // [R03]
      st_nxt.pn_short = PN_SHORT_SEED; // [R03]
    end

    // two-entry buffer toward the formatter
    if (pop) begin
      st_nxt.buf_q[0] = st_r.buf_q[1];
      st_nxt.cnt = st_r.cnt - 2'h1;
    end
    if (acc) begin
      st_nxt.buf_q[st_nxt.cnt[0]] = smp;
      st_nxt.cnt = st_nxt.cnt + 2'h1;
    end
    st_nxt.in_rdy = (st_nxt.cnt != 2'h2);
    st_nxt.out_vld = (st_nxt.cnt != 2'h0);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.ddc_en <= {4{REG_RESET}};
      st_r.mode_a <= REG_RESET;
      st_r.mode_b <= REG_RESET;
      st_r.pn_long <= PN_LONG_SEED;
      st_r.pn_short <= PN_SHORT_SEED;
      st_r.ramp <= RAMP_RESET;
      st_r.in_rdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.dat;
  assign wb_ack_o = st_r.ack;
  assign in_ready_o = st_r.in_rdy;
  assign out_valid_o = st_r.out_vld;
  assign out_o = st_r.buf_q[0];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req_seen;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !st_r.pend;
  endsequence

  sequence s_answer;
    st_r.pend ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_bus_answer: assert property (s_req_seen |=> s_answer)
    else $error("wishbone ack not two cycles after request");

  a_pn_restart: assert property ($rose(st_r.mode_a[TM_PN_LONG_RST]) |=> // [R03]
    (st_r.pn_long == PN_LONG_SEED) && (st_r.pn_short == PN_SHORT_SEED))
    else $error("pn generators not restarted by reset bit");

  a_checker_alt: assert property ((acc && st_r.mode_a[3:0] == MODE_CHECKER && act_a && // [R08]
    !st_r.phase) |-> (smp.i == PAT_CHECK_0) ##1 (st_r.phase == 1'b1))
    else $error("checkerboard word or phase wrong");

  a_toggle_word: assert property ((act_a && st_r.mode_a[3:0] == MODE_TOGGLE) |-> // [R11]
    (smp.i == (st_r.phase ? PAT_ONES : PAT_ZEROS)))
    else $error("toggle word wrong");

  a_ramp_step: assert property (acc && !req |=> // [R14]
    st_r.ramp == $past(st_r.ramp) + 14'h0001)
    else $error("ramp did not advance by one");

  a_user_single: assert property ((act_a && st_r.mode_a[3:0] == MODE_USER && // [R13]
    st_r.mode_a[TM_USER_SINGLE] && st_r.udone) |-> smp.i == PAT_ZEROS)
    else $error("single user mode did not hold zero");

  a_off_pass: assert property ((acc && !code_valid(st_r.mode_a[3:0]) && // [R15]
    st_r.cnt == 2'h0) |=> out_valid_o && out_o.i == $past(adc_i.a) && !out_o.tst_i)
    else $error("converter data not passed through when off");

  a_ddc_gate: assert property ((ddc_mode_i && st_r.ddc_en[0][DDC_EN_Q_BIT] == 1'b0 && // [R05]
    st_r.ddc_en[1][DDC_EN_Q_BIT] == 1'b0 && st_r.ddc_en[2][DDC_EN_Q_BIT] == 1'b0 &&
    st_r.ddc_en[3][DDC_EN_Q_BIT] == 1'b0) |-> !smp.tst_q && smp.q == adc_i.b)
    else $error("q pattern active without ddc enable");

  a_fmt_pn: assert property ((act_a && st_r.mode_a[3:0] == MODE_PN_LONG) |-> // [R02]
    !smp.fmt_i && smp.i == pnl[13:0])
    else $error("pn pattern marked for formatting");

  a_buf_bound: assert property ((st_r.cnt == 2'h2 && !pop) |=> // [R04]
    st_r.cnt == 2'h2 && !in_ready_o)
    else $error("buffer overran or dropped a word");

  a_pn_restart_b: assert property ($rose(st_r.mode_a[TM_PN_SHORT_RST]) |=> // [R03]
    (st_r.pn_long == PN_LONG_SEED) && (st_r.pn_short == PN_SHORT_SEED))
    else $error("pn generators not restarted by second reset bit");

  a_neg_full: assert property ((act_a && st_r.mode_a[3:0] == MODE_NEG_FS) |-> // [R07]
    smp.i == PAT_NEG_FS && smp.fmt_i)
    else $error("negative full scale word wrong");

  a_user_repeat: assert property ((act_a && st_r.mode_a[3:0] == MODE_USER && // [R12]
    !st_r.mode_a[TM_USER_SINGLE]) |-> smp.i == uword[15:2] && !smp.fmt_i)
    else $error("repeat user word wrong");

  a_pn_short_q: assert property ((act_b && st_r.mode_b[3:0] == MODE_PN_SHORT) |-> // [R10]
    !smp.fmt_q && smp.q == pns[13:0])
    else $error("short pn word wrong on q");

  a_ddc_gate_i: assert property ((ddc_mode_i && st_r.ddc_en[0][DDC_EN_I_BIT] == 1'b0 && // [R06]
    st_r.ddc_en[1][DDC_EN_I_BIT] == 1'b0 && st_r.ddc_en[2][DDC_EN_I_BIT] == 1'b0 &&
    st_r.ddc_en[3][DDC_EN_I_BIT] == 1'b0) |-> !smp.tst_i && smp.i == adc_i.a)
    else $error("i pattern active without ddc enable");

endmodule

/* src/tpg_pkg.sv */
// shared constants and carrier types of the converter test pattern generator
// assumes a 32-bit classic wishbone register bus with one register per word
package tpg_pkg;

  localparam int SAMPLE_W = 14;
  localparam int WB_ADR_W = 15;
  localparam int IDX_W = 13;

  // register indices; the byte address on the bus is four times the index
  localparam logic [IDX_W-1:0] IDX_DDC0_TEST = 13'h0327;
  localparam logic [IDX_W-1:0] IDX_DDC1_TEST = 13'h0347;
  localparam logic [IDX_W-1:0] IDX_DDC2_TEST = 13'h0367;
  localparam logic [IDX_W-1:0] IDX_DDC3_TEST = 13'h0387;
  localparam logic [IDX_W-1:0] IDX_TMODE_A = 13'h0550;
  localparam logic [IDX_W-1:0] IDX_UPAT0 = 13'h0551;
  localparam logic [IDX_W-1:0] IDX_UPAT7 = 13'h0558;
  localparam logic [IDX_W-1:0] IDX_TMODE_B = 13'h05F0;

  // field positions
  localparam int TM_PN_LONG_RST = 4;
  localparam int TM_PN_SHORT_RST = 5;
  localparam int TM_USER_SINGLE = 7;
  localparam int DDC_EN_I_BIT = 0;
  localparam int DDC_EN_Q_BIT = 2;

  localparam logic [7:0] REG_RESET = 8'h00;

  // pattern mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_MID = 4'h1;
  localparam logic [3:0] MODE_POS_FS = 4'h2;
  localparam logic [3:0] MODE_NEG_FS = 4'h3;
  localparam logic [3:0] MODE_CHECKER = 4'h4;
  localparam logic [3:0] MODE_PN_LONG = 4'h5;
  localparam logic [3:0] MODE_PN_SHORT = 4'h6;
  localparam logic [3:0] MODE_TOGGLE = 4'h7;
  localparam logic [3:0] MODE_USER = 4'h8;
  localparam logic [3:0] MODE_RAMP = 4'hF;

  // pattern words
  localparam logic [13:0] PAT_MID = 14'h0000;
  localparam logic [13:0] PAT_POS_FS = 14'h1FFF;
  localparam logic [13:0] PAT_NEG_FS = 14'h2000;
  localparam logic [13:0] PAT_CHECK_0 = 14'h1555;
  localparam logic [13:0] PAT_CHECK_1 = 14'h2AAA;
  localparam logic [13:0] PAT_ZEROS = 14'h0000;
  localparam logic [13:0] PAT_ONES = 14'h3FFF;

  localparam logic [22:0] PN_LONG_SEED = 23'h003AFF;
  localparam logic [8:0] PN_SHORT_SEED = 9'h092;
  localparam logic [13:0] RAMP_RESET = 14'h0000;

  typedef struct packed {
    logic [13:0] a;
    logic [13:0] b;
  } adc_pair_t;

  typedef struct packed {
    logic [13:0] i;
    logic [13:0] q;
    logic fmt_i;
    logic fmt_q;
    logic tst_i;
    logic tst_q;
  } sample_t;

endpackage

/* src/user_pattern_mem.sv */
// eight-byte store for the four user pattern words, with registered reads
// assumes writes come from the register bus and word reads from the generator
`timescale 1ns/10ps
module user_pattern_mem (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [2:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [1:0] word_addr_i,
  output logic [15:0] word_o,
  input wire logic [2:0] byte_addr_i,
  output logic [7:0] byte_o
);
  import tpg_pkg::*;

  typedef struct packed {
    logic [7:0][7:0] bytes;
    logic [15:0] word;
    logic [7:0] rbyte;
  } mem_state_t;

  mem_state_t st_r;
  mem_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr_en_i) begin
      st_nxt.bytes[wr_addr_i] = wr_data_i;
    end
    // word k is the byte pair at 2k+1 (high) and 2k (low)
    st_nxt.word = {st_r.bytes[{word_addr_i, 1'b1}], st_r.bytes[{word_addr_i, 1'b0}]};
    st_nxt.rbyte = st_r.bytes[byte_addr_i];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign word_o = st_r.word;
  assign byte_o = st_r.rbyte;

endmodule
